// ### hdl/reload_timer_pkg.sv
package reload_timer_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int TIMER_COUNT = 2;
	localparam int COUNT_W = 8;
	localparam int SEL_W = 4;
	localparam int PRESCALE_W = 14;
	localparam int TICK_COUNT = PRESCALE_W + 1;
	localparam int APB_AW = 32;
	localparam int APB_DW = 32;

	// ****************************************************************
	// Register indices (printed offsets) and byte addresses
	// ****************************************************************
	localparam logic [APB_AW-1:0] FIRST_CLK_IDX = 32'h0000_4240;
	localparam logic [APB_AW-1:0] FIRST_RELOAD_IDX = 32'h0000_4242;
	localparam logic [APB_AW-1:0] FIRST_COUNT_IDX = 32'h0000_4244;
	localparam logic [APB_AW-1:0] FIRST_CTL_IDX = 32'h0000_4246;
	localparam logic [APB_AW-1:0] SECOND_CLK_IDX = 32'h0000_4260;
	localparam logic [APB_AW-1:0] SECOND_RELOAD_IDX = 32'h0000_4262;
	localparam logic [APB_AW-1:0] SECOND_COUNT_IDX = 32'h0000_4264;
	localparam logic [APB_AW-1:0] SECOND_CTL_IDX = 32'h0000_4266;
	localparam int ADDR_SHIFT = 2;

	localparam logic [TIMER_COUNT-1:0][APB_AW-1:0] CLK_ADDR =
		{SECOND_CLK_IDX << ADDR_SHIFT, FIRST_CLK_IDX << ADDR_SHIFT};
	localparam logic [TIMER_COUNT-1:0][APB_AW-1:0] RELOAD_ADDR =
		{SECOND_RELOAD_IDX << ADDR_SHIFT, FIRST_RELOAD_IDX << ADDR_SHIFT};
	localparam logic [TIMER_COUNT-1:0][APB_AW-1:0] COUNT_ADDR =
		{SECOND_COUNT_IDX << ADDR_SHIFT, FIRST_COUNT_IDX << ADDR_SHIFT};
	localparam logic [TIMER_COUNT-1:0][APB_AW-1:0] CTL_ADDR =
		{SECOND_CTL_IDX << ADDR_SHIFT, FIRST_CTL_IDX << ADDR_SHIFT};

	// ****************************************************************
	// Control fields
	// ****************************************************************
	localparam int RUN_BIT = 0;
	localparam int RESET_BIT = 1;
	localparam int MODE_BIT = 4;

	// ****************************************************************
	// Reset values and codes
	// ****************************************************************
	localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
	localparam logic [SEL_W-1:0] SEL_RESERVED = 4'hf;
	localparam logic [COUNT_W-1:0] RELOAD_RST = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_RST = 8'hff;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 8'h01;
	localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 14'h0000;
	localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 14'h0001;

endpackage

// ### hdl/tick_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tick_prescaler
	import reload_timer_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	output logic [reload_timer_pkg::TICK_COUNT-1:0] tick_vec_out
);
	import reload_timer_pkg::*;

	logic [PRESCALE_W-1:0] div_r;

	// Free-running divider shared by both timers
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			div_r <= PRESCALE_RST;
		end else begin
			div_r <= div_r + PRESCALE_ONE;
		end
	end

	// Tick k fires once every 2**k clocks; tick 0 fires every clock
	assign tick_vec_out[0] = 1'b1;
	genvar k;
	generate
		for (k = 1; k < TICK_COUNT; k++) begin : g_tick
			assign tick_vec_out[k] = &div_r[k-1:0];
		end
	endgenerate
endmodule // tick_prescaler
`default_nettype wire

// ### hdl/tick_select.sv
`timescale 1ns/100ps
`default_nettype none
module tick_select
	import reload_timer_pkg::*;
(
	input wire logic [reload_timer_pkg::TICK_COUNT-1:0] tick_vec_in,
	input wire logic [reload_timer_pkg::SEL_W-1:0] tick_divider_select_in,
	output logic tick_out
);
	import reload_timer_pkg::*;

	// Reserved code gives no tick, so a misprogrammed timer just holds
	always_comb begin
		if (tick_divider_select_in == SEL_RESERVED) begin
			tick_out = 1'b0;
		end else begin
			tick_out = tick_vec_in[tick_divider_select_in];
		end
	end
endmodule // tick_select
`default_nettype wire

// ### hdl/dual_eight_bit_reload_timer.sv
// Notes on behaviour
// - Divider code n ticks at clock/2**n; 0xf reserved
// - Reload value in low byte, resets zero
// - Count readable only, resets to all ones
// - Mode bit four: one-shot set, repeat clear
// - Writing one to bit one reloads counter
// - Run bit zero starts/stops, resets stopped
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dual_eight_bit_reload_timer
	import reload_timer_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [reload_timer_pkg::APB_AW-1:0] paddr_in,
	input wire logic [reload_timer_pkg::APB_DW-1:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [reload_timer_pkg::APB_DW-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic [reload_timer_pkg::TIMER_COUNT-1:0] underflow_out
);
	import reload_timer_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	// Bus side
	logic pready_r;
	logic pslverr_r;
	logic [APB_DW-1:0] prdata_r;
	logic [APB_DW-1:0] rdata_nxt;
	logic hit_nxt;
	logic access;
	logic first_access;
	logic commit;
	logic wr_commit;

	// Ticks, decode and strobes
	logic [TICK_COUNT-1:0] tick_vec;
	logic [TIMER_COUNT-1:0] tick;
	logic [TIMER_COUNT-1:0] count_tick;
	logic [TIMER_COUNT-1:0] hit_clk;
	logic [TIMER_COUNT-1:0] hit_reload;
	logic [TIMER_COUNT-1:0] hit_count;
	logic [TIMER_COUNT-1:0] hit_ctl;
	logic [TIMER_COUNT-1:0] wr_clk;
	logic [TIMER_COUNT-1:0] wr_reload;
	logic [TIMER_COUNT-1:0] wr_ctl;
	logic [TIMER_COUNT-1:0] strobe_reset;
	logic [TIMER_COUNT-1:0] wrap;

	// Per-timer state
	logic [TIMER_COUNT-1:0][SEL_W-1:0] tick_divider_select_r;
	logic [TIMER_COUNT-1:0][COUNT_W-1:0] reload_value_r;
	logic [TIMER_COUNT-1:0][COUNT_W-1:0] count_value_r;
	logic [TIMER_COUNT-1:0] one_shot_select_r;
	logic [TIMER_COUNT-1:0] run_control_r;
	logic [TIMER_COUNT-1:0] underflow_r;

	// Next values of the counting state
	logic [TIMER_COUNT-1:0][COUNT_W-1:0] count_value_nxt;
	logic [TIMER_COUNT-1:0] run_control_nxt;

	// ****************************************************************
	// Bus handshake
	// ****************************************************************

	// Access phase of a transfer
	assign access = psel_in & penable_in;

	// First access cycle, before ready; the answer is formed here
	assign first_access = access & ~pready_r;

	// Edge at which the master samples pready high
	assign commit = access & pready_r;

	// Only the low lane carries live bits, so it gates every write
	assign wr_commit = commit & pwrite_in & pstrb_in[0];

	// One wait state: ready rises one cycle into the access phase
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= first_access;
		end
	end

	// Error answer for any address outside the map
	// Unmapped writes change nothing; only this flag answers
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pslverr_r <= 1'b0;
		end else if (first_access) begin
			pslverr_r <= ~hit_nxt;
		end else begin
			pslverr_r <= 1'b0;
		end
	end

	// Read data captured with ready so it is stable at the sample edge
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			prdata_r <= '0;
		end else if (first_access & ~pwrite_in) begin
			prdata_r <= rdata_nxt;
		end else begin
			prdata_r <= '0;
		end
	end

	// ****************************************************************
	// Address decode and read mux
	// ****************************************************************

	// Reserved bits read zero, the write-only strobe reads zero
	// Formed here, registered once in the first access cycle
	always_comb begin
		rdata_nxt = '0;
		hit_nxt = 1'b0;
		// Each address hits at most one register, so the ifs never clash
		for (int t = 0; t < TIMER_COUNT; t++) begin
			if (hit_clk[t]) begin
				rdata_nxt[SEL_W-1:0] = tick_divider_select_r[t];
				hit_nxt = 1'b1;
			end
			if (hit_reload[t]) begin
				rdata_nxt[COUNT_W-1:0] = reload_value_r[t];
				hit_nxt = 1'b1;
			end
			if (hit_count[t]) begin
				rdata_nxt[COUNT_W-1:0] = count_value_r[t];
				hit_nxt = 1'b1;
			end
			if (hit_ctl[t]) begin
				rdata_nxt[MODE_BIT] = one_shot_select_r[t];
				rdata_nxt[RUN_BIT] = run_control_r[t];
				hit_nxt = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Shared prescaler
	// ****************************************************************

	// One divider for both timers keeps their tick phases aligned
	tick_prescaler u_prescaler (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.tick_vec_out(tick_vec)
	);

	// ****************************************************************
	// Timer channels
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < TIMER_COUNT; g++) begin : g_timer

			// ****************************************************************
			// Channel decode
			// ****************************************************************

			// Register hits for this timer
			assign hit_clk[g] = (paddr_in == CLK_ADDR[g]);
			assign hit_reload[g] = (paddr_in == RELOAD_ADDR[g]);
			assign hit_count[g] = (paddr_in == COUNT_ADDR[g]);
			assign hit_ctl[g] = (paddr_in == CTL_ADDR[g]);

			// Write strobes; count register ignores writes
			assign wr_clk[g] = wr_commit & hit_clk[g];
			assign wr_reload[g] = wr_commit & hit_reload[g];
			assign wr_ctl[g] = wr_commit & hit_ctl[g];

			assign strobe_reset[g] = wr_ctl[g] & pwdata_in[RESET_BIT];

			// a tick only counts while running
			assign count_tick[g] = run_control_r[g] & tick[g];

			// underflow on a tick at zero; a same-cycle strobe suppresses it
			assign wrap[g] = count_tick[g] & (count_value_r[g] == COUNT_ZERO) & ~strobe_reset[g];

			// pick the divided tick
			// Reserved code yields no tick, so the count holds
			tick_select u_select (
				.tick_vec_in(tick_vec),
				.tick_divider_select_in(tick_divider_select_r[g]),
				.tick_out(tick[g])
			);

			// ****************************************************************
			// Channel registers
			// ****************************************************************

			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					tick_divider_select_r[g] <= SEL_RST;
				end else if (wr_clk[g]) begin
					tick_divider_select_r[g] <= pwdata_in[SEL_W-1:0];
				end
			end

			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					reload_value_r[g] <= RELOAD_RST;
				end else if (wr_reload[g]) begin
					reload_value_r[g] <= pwdata_in[COUNT_W-1:0];
				end
			end

			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					one_shot_select_r[g] <= 1'b0;
				end else if (wr_ctl[g]) begin
					one_shot_select_r[g] <= pwdata_in[MODE_BIT];
				end
			end

			// ****************************************************************
			// Channel counter
			// ****************************************************************

			// run bit next value; software write wins over one-shot stop
			always_comb begin
				run_control_nxt[g] = run_control_r[g];
				if (wr_ctl[g]) begin
					run_control_nxt[g] = pwdata_in[RUN_BIT];
				end else if (wrap[g] & one_shot_select_r[g]) begin
					run_control_nxt[g] = 1'b0;
				end
			end

			// run bit, cleared by reset so timers start stopped
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					run_control_r[g] <= 1'b0;
				end else begin
					run_control_r[g] <= run_control_nxt[g];
				end
			end

			// counter next value; strobe outranks underflow and tick
			always_comb begin
				count_value_nxt[g] = count_value_r[g];
				if (strobe_reset[g]) begin
					count_value_nxt[g] = reload_value_r[g];
				end else if (wrap[g]) begin
					count_value_nxt[g] = reload_value_r[g];
				end else if (count_tick[g]) begin
					count_value_nxt[g] = count_value_r[g] - COUNT_ONE;
				end
			end

			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					count_value_r[g] <= COUNT_RST;
				end else begin
					count_value_r[g] <= count_value_nxt[g];
				end
			end

			// Underflow pulse for whatever consumes the timer
			// Registered, so the pulse lags the wrap by one cycle
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					underflow_r[g] <= 1'b0;
				end else begin
					underflow_r[g] <= wrap[g];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// All outputs straight from flip-flops
	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;
	assign underflow_out = underflow_r;

endmodule // dual_eight_bit_reload_timer
`default_nettype wire

// ### test/reload_timer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module reload_timer_chk (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [reload_timer_pkg::APB_AW-1:0] paddr_in,
	input wire logic [reload_timer_pkg::APB_DW-1:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [reload_timer_pkg::APB_DW-1:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [reload_timer_pkg::TIMER_COUNT-1:0] underflow_out
);
	import reload_timer_pkg::*;
	// ****************
	// Bus and timer checks
	// ****************
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence s_setup; psel_in && !penable_in; endsequence
	sequence s_access; psel_in && penable_in; endsequence
	a_ready_wait: assert property (s_setup ##1 s_access |=> pready_out)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
		else $error("ready without access");
	a_err_pair: assert property (pslverr_out |-> pready_out && prdata_out == '0)
		else $error("error without ready or with data");
	a_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
		else $error("reserved bits not zero");
	a_ctl_strobe: assert property (pready_out && !pwrite_in && paddr_in == CTL_ADDR[0] |-> prdata_out[3:1] == 3'h0)
		else $error("strobe bit reads back");
	a_sel_field: assert property (pready_out && !pwrite_in && paddr_in == CLK_ADDR[1] |-> prdata_out[7:4] == 4'h0)
		else $error("select upper bits set");
	// Timers leave reset stopped, so no underflow can follow at once
	a_stop_reset: assert property ($fell(rst_in) |-> (underflow_out == 2'h0) [*4])
		else $error("underflow right after reset");
endmodule // reload_timer_chk
bind dual_eight_bit_reload_timer reload_timer_chk u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .underflow_out(underflow_out));
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import reload_timer_pkg::*;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
	logic [3:0] strb = 4'hf;
	logic [31:0] addr = '0, wdat = '0, rdat, d;
	logic rdy, err;
	logic [1:0] uf;
	logic [32:0] q[$];
	logic [32:0] n;
	int uq[$];
	int err_count = 0, checked = 0, cyc = 0, last = 0, seed = 19;
	int codes[4] = '{0, 1, 5, 14};
	dual_eight_bit_reload_timer DUT (.mclk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(addr), .pwdata_in(wdat), .pstrb_in(strb), .prdata_out(rdat), .pready_out(rdy), .pslverr_out(err),
		.underflow_out(uf));
	// ****************
	// Clock and tasks
	// ****************
	always #2.5 clk = ~clk;
	task automatic chk(input string s, input logic [31:0] e, g);
		checked++;
		if (e !== g) begin
			err_count++;
			$display("Error %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic chk_gap(input logic [31:0] e, g);
		checked++;
		if (e !== g) begin
			err_count++;
			$display("Error interval exp %0d got %0d", e, g);
		end
	endtask
	// Expected answer is queued before the request goes out
	task automatic apb(input logic w, input logic [31:0] a, v, e, input logic x = 1'b0, input logic [3:0] s = 4'hf);
		q.push_back({x, e});
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		addr <= a;
		wdat <= v;
		strb <= s;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, v);
		apb(1'b1, a, v, 32'h0);
	endtask
	task automatic wuf(input int t);
		@(posedge clk);
		while (uf[t] !== 1'b1) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("Checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Monitor: bus answers and underflow spacing
	always @(posedge clk) begin
		cyc++;
		if (rdy === 1'b1) begin
			n = q.pop_front();
			chk("prdata", n[31:0], rdat);
			chk("pslverr", {31'h0, n[32]}, {31'h0, err});
		end
		if (uf[1] === 1'b1) begin
			if (uq.size() > 0) chk_gap(32'(uq.pop_front()), 32'(cyc - last));
			last = cyc;
		end
	end
	// Longest case is two slowest periods; allow nearly twice that
	initial begin
		#300000;
		err_count++;
		complete_run();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int t = 0; t < 2; t++) begin
			apb(1'b0, CLK_ADDR[t], 0, 32'h0);
			apb(1'b0, RELOAD_ADDR[t], 0, 32'h0);
			apb(1'b0, COUNT_ADDR[t], 0, 32'hff);
			apb(1'b0, CTL_ADDR[t], 0, 32'h0);
		end
		d = $random(seed);
		wr(RELOAD_ADDR[0], d);
		apb(1'b0, RELOAD_ADDR[0], 0, {24'h0, d[7:0]});
		// Low lane strobe off: the write must be dropped
		apb(1'b1, RELOAD_ADDR[0], ~d, 32'h0, 1'b0, 4'he);
		apb(1'b0, RELOAD_ADDR[0], 0, {24'h0, d[7:0]});
		wr(COUNT_ADDR[0], 32'h0);
		wr(CTL_ADDR[0], 32'h2);
		apb(1'b0, COUNT_ADDR[0], 0, {24'h0, d[7:0]});
		apb(1'b0, CTL_ADDR[0], 0, 32'h0);
		apb(1'b0, 32'h0, 0, 32'h0, 1'b1);
		// One-shot stops itself after one underflow
		wr(RELOAD_ADDR[0], 32'h3);
		wr(CTL_ADDR[0], 32'h13);
		wuf(0);
		apb(1'b0, CTL_ADDR[0], 0, 32'h10);
		apb(1'b0, COUNT_ADDR[0], 0, 32'h3);
		// Reserved code must hold the count still
		wr(CLK_ADDR[1], 32'hf);
		wr(RELOAD_ADDR[1], 32'h5);
		wr(CTL_ADDR[1], 32'h3);
		repeat (40) @(posedge clk);
		apb(1'b0, COUNT_ADDR[1], 0, 32'h5);
		// Stop, reprogram, restart from reload: the gap from the first to the second pulse must match the new period
		foreach (codes[i]) begin
			wr(CTL_ADDR[1], 32'h0);
			wr(RELOAD_ADDR[1], codes[i] == 14 ? 32'h0 : 32'h2);
			wr(CLK_ADDR[1], codes[i]);
			wr(CTL_ADDR[1], 32'h3);
			wuf(1);
			@(posedge clk);
			uq.push_back(((codes[i] == 14 ? 0 : 2) + 1) << codes[i]);
			wuf(1);
			@(posedge clk);
		end
		wr(CTL_ADDR[1], 32'h0);
		// Let the monitor take the last answer before the verdict
		repeat (2) @(posedge clk);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
